// file: rtl/wrsc_core.sv
`timescale 1ns/100ps

module wrsc_core #(
  parameter logic [wrsc_pkg::WDOG_CNT_W-1:0] BUS_CNT1 = wrsc_pkg::BUS_CNT1,
  parameter logic [wrsc_pkg::WDOG_CNT_W-1:0] BUS_CNT2 = wrsc_pkg::BUS_CNT2,
  parameter logic [wrsc_pkg::WDOG_CNT_W-1:0] BUS_CNT3 = wrsc_pkg::BUS_CNT3,
  parameter logic [wrsc_pkg::WDOG_CNT_W-1:0] BUS_WIN1 = wrsc_pkg::BUS_WIN1,
  parameter logic [wrsc_pkg::WDOG_CNT_W-1:0] BUS_WIN2 = wrsc_pkg::BUS_WIN2,
  parameter logic [wrsc_pkg::WDOG_CNT_W-1:0] BUS_WIN3 = wrsc_pkg::BUS_WIN3
) (
  // Clock and synchronous reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Processor register access.
  input wire wrsc_pkg::wrsc_req_s cpu_req,
  output logic [7:0] cpu_rdata,
  // Background debug register access.
  input wire wrsc_pkg::wrsc_req_s debug_req,
  // Processor core events.
  input wire logic illegal_opcode_exec,
  input wire logic stop_exec,
  input wire logic background_instruction_exec,
  input wire logic background_mode_allow,
  // Clock and power monitors.
  input wire logic low_power_osc,
  input wire logic clock_loss,
  input wire logic low_voltage_trip,
  input wire logic low_voltage_reset_allow,
  input wire logic low_voltage_stop_allow,
  input wire logic power_on_reset,
  // Results towards the system.
  output logic device_reset_req,
  output logic stop_enter,
  output logic stop_allow
);

  localparam int CW = wrsc_pkg::WDOG_CNT_W;

  // Stored registers.
  logic [7:0] opts_once_reg, opts_once_next;
  logic [7:0] wdog_opts_reg, wdog_opts_next;
  logic opts_lock_reg, opts_lock_next;
  logic wdog_lock_reg, wdog_lock_next;
  wrsc_pkg::wrsc_cause_s flags_reg, flags_next;
  wrsc_pkg::wrsc_cause_s cause_reg, cause_next;
  logic req_reg, req_next;
  logic key_seen_reg, key_seen_next;
  logic [CW-1:0] count_reg, count_next;
  logic [7:0] rdata_reg, rdata_next;

  // Two-stage synchroniser and edge history for the low-power oscillator.
  logic lpo_meta_reg;
  logic lpo_sync_reg;
  logic lpo_prev_reg;

  // Overflow count for a timeout code and clock choice; zero means disabled.
  function automatic logic [CW-1:0] overflow_count(input logic [1:0] code,
                                                   input logic bus_sel);
    logic [CW-1:0] result;
    result = '0;
    unique case (code)
      2'h1: result = bus_sel ? BUS_CNT1 : wrsc_pkg::LPO_CNT1;
      2'h2: result = bus_sel ? BUS_CNT2 : wrsc_pkg::LPO_CNT2;
      2'h3: result = bus_sel ? BUS_CNT3 : wrsc_pkg::LPO_CNT3;
      default: result = '0;
    endcase
    return result;
  endfunction

  // Count at which the service window opens on the bus clock.
  function automatic logic [CW-1:0] window_open(input logic [1:0] code);
    logic [CW-1:0] result;
    result = '0;
    unique case (code)
      2'h1: result = BUS_WIN1;
      2'h2: result = BUS_WIN2;
      2'h3: result = BUS_WIN3;
      default: result = '0;
    endcase
    return result;
  endfunction

  // Option fields decoded from the write-once registers.
  wire logic [1:0] timeout_sel = opts_once_reg[wrsc_pkg::TIMEOUT_LSB +: 2];
  wire logic clock_sel = wdog_opts_reg[wrsc_pkg::CLOCK_SEL_BIT];
  wire logic window_mode = wdog_opts_reg[wrsc_pkg::WINDOW_BIT];

  // The watchdog runs only when a nonzero timeout code is chosen.
  wire logic watchdog_allow = (timeout_sel != 2'h0);

  // One tick per bus cycle, or one per rising oscillator edge.
  wire logic lpo_rise = lpo_sync_reg & ~lpo_prev_reg;
  wire logic tick = clock_sel ? 1'b1 : lpo_rise;

  // Overflow limit and window threshold for the current settings.
  wire logic [CW-1:0] limit = overflow_count(timeout_sel, clock_sel);
  wire logic [CW-1:0] win_open = window_open(timeout_sel);
  wire logic overflow = watchdog_allow & tick & (count_reg == limit - CW'(1));

  // The window only has meaning on the bus clock, where opening counts exist.
  wire logic window_active = window_mode & clock_sel;
  wire logic too_early = window_active & (count_reg < win_open);

  // Processor writes decoded per register.
  wire logic wr_flags = cpu_req.wr & (cpu_req.idx == wrsc_pkg::IDX_FLAGS);
  wire logic wr_opts = cpu_req.wr & (cpu_req.idx == wrsc_pkg::IDX_OPTS_ONCE);
  wire logic wr_wdog = cpu_req.wr & (cpu_req.idx == wrsc_pkg::IDX_WDOG_OPTS);

  // Service sequence decode on writes to the flags register.
  wire logic is_first_key = (cpu_req.data == wrsc_pkg::SERVICE_KEY_FIRST);
  wire logic is_second_key = (cpu_req.data == wrsc_pkg::SERVICE_KEY_SECOND);
  wire logic good_key = is_first_key | (is_second_key & key_seen_reg);
  wire logic service_done = wr_flags & watchdog_allow & is_second_key & key_seen_reg
                            & ~too_early;
  wire logic bad_service = wr_flags & watchdog_allow & (~good_key | too_early);

  // Only the debug host can force a reset; processor writes never reach it.
  wire logic debug_force = debug_req.wr & (debug_req.idx == wrsc_pkg::IDX_DEBUG)
                           & debug_req.data[wrsc_pkg::FORCE_RESET_BIT];

  // Illegal opcode sources, including stop and background when not allowed.
  wire logic stop_illegal = stop_exec & ~stop_allow;
  wire logic background_instruction_illegal = background_instruction_exec & ~background_mode_allow;
  wire logic illegal_opcode_flag_event = illegal_opcode_exec | stop_illegal | background_instruction_illegal;

  // Low-voltage trip acts only while reset or stop detection is allowed.
  wire logic lvd_event = low_voltage_trip
                         & (low_voltage_reset_allow | low_voltage_stop_allow);

  // Causes seen this cycle; a debug reset carries no cause.
  wire wrsc_pkg::wrsc_cause_s cause_now = '{
    wdog: (overflow | bad_service),
    illegal_opcode_flag: illegal_opcode_flag_event,
    clock_loss_flag: clock_loss,
    low_voltage_flag: lvd_event
  };
  wire logic any_request = cause_now.wdog | cause_now.illegal_opcode_flag | cause_now.clock_loss_flag
                           | cause_now.low_voltage_flag | debug_force;

  // Flags register as read, with unused bits at zero.
  wire logic [7:0] flags_read = {2'h0, flags_reg.wdog, flags_reg.illegal_opcode_flag, 1'b0,
                                 flags_reg.clock_loss_flag, flags_reg.low_voltage_flag, 1'b0};

  // Read data selection; the debug register reads as a constant.
  wire logic [7:0] read_mux =
    (cpu_req.idx == wrsc_pkg::IDX_FLAGS) ? flags_read :
    (cpu_req.idx == wrsc_pkg::IDX_DEBUG) ? wrsc_pkg::DEBUG_READ_VALUE :
    (cpu_req.idx == wrsc_pkg::IDX_OPTS_ONCE) ?
      (opts_once_reg & ~wrsc_pkg::OPTS_UNIMPL_MASK) :
      (wdog_opts_reg & wrsc_pkg::WDOG_OPTS_MASK);

  // Next-state logic for normal operation and for reset.
  always_comb begin
    opts_once_next = opts_once_reg;
    wdog_opts_next = wdog_opts_reg;
    opts_lock_next = opts_lock_reg;
    wdog_lock_next = wdog_lock_reg;
    flags_next = flags_reg;
    cause_next = cause_reg;
    req_next = req_reg;
    key_seen_next = key_seen_reg;
    count_next = count_reg;
    rdata_next = rdata_reg;
    if (!reset_n) begin
      // Options return to defaults and unlock.
      opts_once_next = wrsc_pkg::OPTS_ONCE_RESET;
      wdog_opts_next = wrsc_pkg::WDOG_OPTS_RESET;
      opts_lock_next = 1'b0;
      wdog_lock_next = 1'b0;
      req_next = 1'b0;
      key_seen_next = 1'b0;
      count_next = '0;
      rdata_next = 8'h00;
      if (power_on_reset) begin
        // Power-on marks only the low-voltage flag.
        flags_next = '{wdog: 1'b0, illegal_opcode_flag: 1'b0, clock_loss_flag: 1'b0, low_voltage_flag: 1'b1};
        cause_next = '0;
      end else begin
        // Held causes become the flags; absent causes read as zero.
        flags_next = cause_reg;
      end
    end else begin
      // Causes are tracked each cycle until a request is pending.
      if (!req_reg) begin
        cause_next = cause_now;
      end
      // A request stays raised until the system applies reset.
      if (any_request) begin
        req_next = 1'b1;
      end
      // Only the first write after reset lands in each options register.
      if (wr_opts && !opts_lock_reg) begin
        opts_once_next = cpu_req.data & ~wrsc_pkg::OPTS_UNIMPL_MASK;
        opts_lock_next = 1'b1;
      end
      if (wr_wdog && !wdog_lock_reg) begin
        wdog_opts_next = cpu_req.data & wrsc_pkg::WDOG_OPTS_MASK;
        wdog_lock_next = 1'b1;
      end
      // Key progress: the first key arms, anything else disarms.
      if (wr_flags) begin
        key_seen_next = is_first_key;
      end
      // Counter clears when disabled or on service, otherwise advances on each tick until overflow.
      if (!watchdog_allow || service_done) begin
        count_next = '0;
      end else if (tick && !overflow) begin
        count_next = count_reg + CW'(1);
      end
      // Read data is captured on a read strobe.
      if (cpu_req.rd) begin
        rdata_next = read_mux;
      end
    end
  end

  // State registers, all updated each clock.
  always_ff @(posedge clk_sys) begin
    opts_once_reg <= opts_once_next;
    wdog_opts_reg <= wdog_opts_next;
    opts_lock_reg <= opts_lock_next;
    wdog_lock_reg <= wdog_lock_next;
    flags_reg <= flags_next;
    cause_reg <= cause_next;
    req_reg <= req_next;
    key_seen_reg <= key_seen_next;
    count_reg <= count_next;
    rdata_reg <= rdata_next;
  end

  // Oscillator pin passes two flip-flops before the edge detector reads it.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lpo_meta_reg <= 1'b0;
      lpo_sync_reg <= 1'b0;
      lpo_prev_reg <= 1'b0;
    end else begin
      lpo_meta_reg <= low_power_osc;
      lpo_sync_reg <= lpo_meta_reg;
      lpo_prev_reg <= lpo_sync_reg;
    end
  end

  // Output drives.
  assign device_reset_req = req_reg;
  assign cpu_rdata = rdata_reg;
  assign stop_allow = opts_once_reg[wrsc_pkg::STOP_ALLOW_BIT];
  assign stop_enter = stop_exec & stop_allow;

endmodule

// file: rtl/wrsc_pkg.sv
package wrsc_pkg;

  // Register indices on the register port.
  localparam logic [1:0] IDX_FLAGS = 2'h0;
  localparam logic [1:0] IDX_DEBUG = 2'h1;
  localparam logic [1:0] IDX_OPTS_ONCE = 2'h2;
  localparam logic [1:0] IDX_WDOG_OPTS = 2'h3;

  // Bit positions in reset_source_flags.
  localparam int FLAG_WDOG_BIT = 5;
  localparam int FLAG_ILLEGAL_OPCODE_FLAG_BIT = 4;
  localparam int FLAG_LOC_BIT = 2;
  localparam int FLAG_LVD_BIT = 1;

  // Bit positions in system_options_once and in the watchdog options register.
  localparam int TIMEOUT_LSB = 6;
  localparam int STOP_ALLOW_BIT = 5;
  localparam logic [7:0] OPTS_UNIMPL_MASK = 8'h0c;
  localparam int CLOCK_SEL_BIT = 7;
  localparam int WINDOW_BIT = 6;
  localparam logic [7:0] WDOG_OPTS_MASK = 8'hc0;

  // Bit position of force_reset_bit in debug_forced_reset.
  localparam int FORCE_RESET_BIT = 0;

  // Reset and read values.
  localparam logic [7:0] OPTS_ONCE_RESET = 8'hc0;
  localparam logic [7:0] WDOG_OPTS_RESET = 8'h00;
  localparam logic [7:0] DEBUG_READ_VALUE = 8'h00;

  // Service key bytes, first and second.
  localparam logic [7:0] SERVICE_KEY_FIRST = 8'h55;
  localparam logic [7:0] SERVICE_KEY_SECOND = 8'haa;

  // Counter width holds the largest overflow count.
  localparam int WDOG_CNT_W = 19;

  // Low-power oscillator period and nominal timeouts in its time base.
  localparam int LPO_PERIOD_US = 1000;
  localparam int LPO_TIMEOUT1_MS = 32;
  localparam int LPO_TIMEOUT2_MS = 256;
  localparam int LPO_TIMEOUT3_MS = 1024;
  localparam logic [WDOG_CNT_W-1:0] LPO_CNT1 =
    WDOG_CNT_W'(LPO_TIMEOUT1_MS * 1000 / LPO_PERIOD_US);
  localparam logic [WDOG_CNT_W-1:0] LPO_CNT2 =
    WDOG_CNT_W'(LPO_TIMEOUT2_MS * 1000 / LPO_PERIOD_US);
  localparam logic [WDOG_CNT_W-1:0] LPO_CNT3 =
    WDOG_CNT_W'(LPO_TIMEOUT3_MS * 1000 / LPO_PERIOD_US);

  // Bus clock overflow counts and window opening counts.
  localparam logic [WDOG_CNT_W-1:0] BUS_CNT1 = 19'h02000;
  localparam logic [WDOG_CNT_W-1:0] BUS_CNT2 = 19'h10000;
  localparam logic [WDOG_CNT_W-1:0] BUS_CNT3 = 19'h40000;
  localparam logic [WDOG_CNT_W-1:0] BUS_WIN1 = 19'h01800;
  localparam logic [WDOG_CNT_W-1:0] BUS_WIN2 = 19'h0c000;
  localparam logic [WDOG_CNT_W-1:0] BUS_WIN3 = 19'h30000;

  // Register access request from the processor or from the debug host.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] idx;
    logic [7:0] data;
  } wrsc_req_s;

  // Reset causes that this block records.
  typedef struct packed {
    logic wdog;
    logic illegal_opcode_flag;
    logic clock_loss_flag;
    logic low_voltage_flag;
  } wrsc_cause_s;

endpackage

// file: sim/wrsc_core_sva.sv
`timescale 1ns/100ps
// Ties each reset request except the watchdog's, and the debug and options reads, to its cause at the ports.
module wrsc_core_sva (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register access.
  input wire wrsc_pkg::wrsc_req_s cpu_req,
  input wire logic [7:0] cpu_rdata,
  input wire wrsc_pkg::wrsc_req_s debug_req,
  // Core events and monitors.
  input wire logic illegal_opcode_exec,
  input wire logic stop_exec,
  input wire logic background_instruction_exec,
  input wire logic background_mode_allow,
  input wire logic clock_loss,
  input wire logic low_voltage_trip,
  input wire logic low_voltage_reset_allow,
  input wire logic low_voltage_stop_allow,
  // Results.
  input wire logic device_reset_req,
  input wire logic stop_enter,
  input wire logic stop_allow
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  debug_reset_a: assert property (debug_req.wr && debug_req.idx == wrsc_pkg::IDX_DEBUG
    && debug_req.data[0] |=> device_reset_req) else $error("debug force did not reset");
  illegal_opcode_flag_reset_a: assert property (illegal_opcode_exec |=> device_reset_req)
    else $error("illegal opcode did not reset");
  bg_instr_reset_a: assert property (background_instruction_exec && !background_mode_allow
    |=> device_reset_req) else $error("background instruction did not reset");
  stop_block_a: assert property (stop_exec && !stop_allow |-> !stop_enter ##1 device_reset_req)
    else $error("disallowed stop not turned into reset");
  stop_pass_a: assert property (stop_exec && stop_allow |-> stop_enter)
    else $error("allowed stop not entered");
  clock_loss_a: assert property (clock_loss |=> device_reset_req)
    else $error("clock loss did not reset");
  low_volt_a: assert property (low_voltage_trip && (low_voltage_reset_allow ||
    low_voltage_stop_allow) |=> device_reset_req) else $error("low voltage did not reset");
  req_hold_a: assert property (device_reset_req |=> device_reset_req)
    else $error("reset request dropped early");
  debug_read_a: assert property (cpu_req.rd && cpu_req.idx == wrsc_pkg::IDX_DEBUG
    |=> cpu_rdata == wrsc_pkg::DEBUG_READ_VALUE) else $error("debug register read not zero");
  opts_zero_a: assert property (cpu_req.rd && cpu_req.idx == wrsc_pkg::IDX_OPTS_ONCE
    |=> (cpu_rdata & wrsc_pkg::OPTS_UNIMPL_MASK) == 8'h00) else $error("options bits 3:2 set");
endmodule

bind wrsc_core wrsc_core_sva chk (.clk_sys(clk_sys), .reset_n(reset_n), .cpu_req(cpu_req),
  .cpu_rdata(cpu_rdata), .debug_req(debug_req), .illegal_opcode_exec(illegal_opcode_exec),
  .stop_exec(stop_exec), .background_instruction_exec(background_instruction_exec),
  .background_mode_allow(background_mode_allow), .clock_loss(clock_loss),
  .low_voltage_trip(low_voltage_trip), .low_voltage_reset_allow(low_voltage_reset_allow),
  .low_voltage_stop_allow(low_voltage_stop_allow), .device_reset_req(device_reset_req),
  .stop_enter(stop_enter), .stop_allow(stop_allow));

// file: sim/wrsc_debug_host.sv
`timescale 1ns/100ps
// Stands in for the debug host and the free-running low-power oscillator.
module wrsc_debug_host #(
  parameter int LPO_HALF = 4
) (
  // Bench clock.
  input wire logic clk_sys,
  // Bench command: send one background write of kick_data.
  input wire logic kick,
  input wire logic [7:0] kick_data,
  // Towards the block.
  output wrsc_pkg::wrsc_req_s debug_req,
  output logic low_power_osc
);
  // The oscillator never stops; the odd offset keeps it off the bus clock edges.
  initial begin
    low_power_osc = 1'b0;
    forever begin
      repeat (LPO_HALF) @(posedge clk_sys);
      #7 low_power_osc = ~low_power_osc;
    end
  end
  // A write lasts one cycle; between writes the released lines carry random junk.
  // This is the only process that drives the request lines.
  always @(posedge clk_sys) begin
    if (kick) begin
      debug_req <= '{wr: 1'b1, rd: 1'b0, idx: wrsc_pkg::IDX_DEBUG, data: kick_data};
    end else begin
      debug_req <= '{wr: 1'b0, rd: 1'b0, idx: 2'($urandom), data: 8'($urandom)};
    end
  end
endmodule

// file: sim/tb.sv
`timescale 1ns/100ps
// Self-checking bench for the watchdog and reset-source block.
module tb;
  localparam int LPO_HALF = 4; // Oscillator half period in bus cycles.
  localparam logic [1:0] FL = wrsc_pkg::IDX_FLAGS;
  localparam logic [1:0] OP = wrsc_pkg::IDX_OPTS_ONCE;
  localparam logic [1:0] WO = wrsc_pkg::IDX_WDOG_OPTS;
  logic clk_sys, reset_n, kick, power_on_reset, device_reset_req, stop_enter, stop_allow;
  logic illegal_opcode_exec, stop_exec, background_instruction_exec, background_mode_allow;
  logic low_power_osc, clock_loss, low_voltage_trip, low_voltage_reset_allow;
  logic low_voltage_stop_allow;
  logic [7:0] cpu_rdata, kick_data, v;
  wrsc_pkg::wrsc_req_s cpu_req, debug_req;
  int miscompares, n_checks, n;

  // Bus counts shortened to 64, 128 and 256 with windows at three quarters.
  wrsc_core #(.BUS_CNT1(19'h40), .BUS_CNT2(19'h80), .BUS_CNT3(19'h100), .BUS_WIN1(19'h30),
    .BUS_WIN2(19'h60), .BUS_WIN3(19'hc0)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .debug_req(debug_req),
    .illegal_opcode_exec(illegal_opcode_exec), .stop_exec(stop_exec),
    .background_instruction_exec(background_instruction_exec),
    .background_mode_allow(background_mode_allow), .low_power_osc(low_power_osc),
    .clock_loss(clock_loss), .low_voltage_trip(low_voltage_trip),
    .low_voltage_reset_allow(low_voltage_reset_allow),
    .low_voltage_stop_allow(low_voltage_stop_allow), .power_on_reset(power_on_reset),
    .device_reset_req(device_reset_req), .stop_enter(stop_enter), .stop_allow(stop_allow));
  wrsc_debug_host #(.LPO_HALF(LPO_HALF)) host (.clk_sys(clk_sys), .kick(kick),
    .kick_data(kick_data), .debug_req(debug_req), .low_power_osc(low_power_osc));

  // The 40 MHz bus clock.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Flags expected after a reset from entry i of the cause table; 7 is the watchdog.
  function automatic logic [7:0] cause_flags(input int i);
    case (i)
      0, 1, 2: return 8'h01 << wrsc_pkg::FLAG_ILLEGAL_OPCODE_FLAG_BIT;
      3: return 8'h01 << wrsc_pkg::FLAG_LOC_BIT;
      4, 5: return 8'h01 << wrsc_pkg::FLAG_LVD_BIT;
      7: return 8'h01 << wrsc_pkg::FLAG_WDOG_BIT;
      default: return 8'h00;
    endcase
  endfunction

  // Compares one value and counts it.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One processor write; idle lines carry the inverse afterwards.
  task automatic cpu_wr(input logic [1:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    cpu_req <= '{wr: 1'b1, rd: 1'b0, idx: idx, data: d};
    @(posedge clk_sys);
    cpu_req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: ~d};
  endtask

  // One processor read; the data is settled one cycle after the strobe.
  task automatic cpu_rd(input logic [1:0] idx, input string what, input logic [7:0] exp);
    @(posedge clk_sys);
    cpu_req <= '{wr: 1'b0, rd: 1'b1, idx: idx, data: 8'h00};
    @(posedge clk_sys);
    cpu_req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: 8'h5a};
    #1 check(what, exp, cpu_rdata);
  endtask

  // The two-byte service sequence.
  task automatic service();
    cpu_wr(FL, wrsc_pkg::SERVICE_KEY_FIRST);
    cpu_wr(FL, wrsc_pkg::SERVICE_KEY_SECOND);
  endtask

  // Counts cycles until a reset request; running out ends the run.
  task automatic wait_req(input int max);
    n = 0;
    while (device_reset_req !== 1'b1 && n < max) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (device_reset_req !== 1'b1) begin
      $display("MISMATCH reset request expected 1 seen %b", device_reset_req);
      miscompares++;
      finish_test();
    end
  endtask

  // Lets time pass, then expects no reset request.
  task automatic quiet(input int cycles);
    repeat (cycles) @(posedge clk_sys);
    #1 check("no reset", 8'h00, {7'h00, device_reset_req});
  endtask

  // A short system reset, optionally marked as power-on.
  task automatic do_reset(input logic por);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    power_on_reset <= por;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    power_on_reset <= 1'b0;
  endtask

  // Main sequence.
  initial begin
    {reset_n, kick, kick_data, cpu_req, illegal_opcode_exec, stop_exec, clock_loss} = '0;
    {background_instruction_exec, background_mode_allow, low_voltage_trip} = '0;
    {low_voltage_reset_allow, low_voltage_stop_allow} = '0;
    power_on_reset = 1'b1;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(32'hd0bb8c22));
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    power_on_reset <= 1'b0;
    // Power-on leaves only the low-voltage flag; stop starts disallowed.
    cpu_rd(FL, "flags after power-on", cause_flags(4));
    cpu_rd(wrsc_pkg::IDX_DEBUG, "debug read", 8'h00);
    cpu_rd(OP, "options reset", wrsc_pkg::OPTS_ONCE_RESET & 8'hf3);
    check("stop allow", 8'h00, {7'h00, stop_allow});
    // Random options with the watchdog off and stop allowed; the second write is lost.
    v = {3'h1, 5'($urandom)};
    cpu_wr(OP, v);
    cpu_wr(OP, ~v);
    cpu_rd(OP, "options once", v & 8'hf3);
    cpu_wr(wrsc_pkg::IDX_DEBUG, 8'h01);
    cpu_wr(FL, 8'($urandom));
    kick <= 1'b1;
    @(posedge clk_sys);
    kick <= 1'b0;
    stop_exec <= 1'b1;
    #1 check("stop enter", 8'h01, {7'h00, stop_enter});
    @(posedge clk_sys);
    stop_exec <= 1'b0;
    // A background instruction while background mode is allowed is legal.
    background_mode_allow <= 1'b1;
    background_instruction_exec <= 1'b1;
    @(posedge clk_sys);
    background_instruction_exec <= 1'b0;
    @(posedge clk_sys);
    background_mode_allow <= 1'b0;
    quiet(300);
    // Bus-clock timeout of each code, measured from a completed service.
    for (int c = 1; c < 4; c++) begin
      do_reset(1'b0);
      cpu_wr(WO, 8'h80);
      cpu_wr(OP, 8'(c << 6));
      service();
      wait_req(1000);
      check("bus timeout", 8'h01, 8'(n >= (32 << c) - 2 && n <= (32 << c) + 2));
      do_reset(1'b0);
      cpu_rd(FL, "timeout flag", cause_flags(7));
    end
    // Regular service holds the timer off; a wrong key trips it.
    do_reset(1'b0);
    cpu_wr(WO, 8'h80);
    cpu_wr(OP, 8'h40);
    repeat (6) begin
      repeat (40) @(posedge clk_sys);
      service();
    end
    quiet(1);
    cpu_wr(FL, 8'($urandom) & 8'hfe);
    wait_req(4);
    do_reset(1'b0);
    cpu_rd(FL, "bad key flag", cause_flags(7));
    // Window mode: a late service passes, an early write trips.
    do_reset(1'b0);
    cpu_wr(WO, 8'hc0);
    cpu_wr(OP, 8'h40);
    repeat (50) @(posedge clk_sys);
    service();
    quiet(1);
    cpu_wr(FL, wrsc_pkg::SERVICE_KEY_FIRST);
    wait_req(4);
    // Low-power clock, shortest code: the timeout counts oscillator rises.
    do_reset(1'b0);
    cpu_wr(WO, 8'h00);
    cpu_wr(OP, 8'h40);
    service();
    wait_req(400);
    check("lpo timeout", 8'h01, 8'(n >= 62 * LPO_HALF && n <= 66 * LPO_HALF));
    // Each reset cause leaves its own flag and clears the rest; the debug force leaves none.
    kick_data <= 8'h01;
    for (int i = 0; i < 7; i++) begin
      do_reset(1'b0);
      @(posedge clk_sys);
      case (i)
        0: illegal_opcode_exec <= 1'b1;
        1: background_instruction_exec <= 1'b1;
        2: stop_exec <= 1'b1;
        3: clock_loss <= 1'b1;
        4: {low_voltage_trip, low_voltage_reset_allow} <= 2'h3;
        5: {low_voltage_trip, low_voltage_stop_allow} <= 2'h3;
        default: kick <= 1'b1;
      endcase
      @(posedge clk_sys);
      {illegal_opcode_exec, background_instruction_exec, stop_exec, clock_loss} <= 4'h0;
      {low_voltage_trip, low_voltage_reset_allow, low_voltage_stop_allow, kick} <= 4'h0;
      wait_req(8);
      do_reset(1'b0);
      cpu_rd(FL, "cause flags", cause_flags(i));
    end
    finish_test();
  end
endmodule
